// file: pkg/gtimer_pkg.sv
package gtimer_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_SMCFG   = 8'h04;
    localparam logic [7:0] OFF_PSC     = 8'h08;
    localparam logic [7:0] OFF_CAR     = 8'h0c;
    localparam logic [7:0] OFF_CNT     = 8'h10;
    localparam logic [7:0] OFF_STAT    = 8'h14;
    localparam logic [7:0] OFF_MASK    = 8'h18;
    localparam logic [7:0] OFF_CHCV0   = 8'h20;
    localparam logic [7:0] OFF_CHCTL   = 8'h30;
    localparam logic [7:0] OFF_SWEV    = 8'h34;
    // Control register fields
    localparam int CTRL_CEN   = 0;
    localparam int CTRL_DIR   = 1;
    localparam int CTRL_CAM   = 2;
    localparam int CTRL_SYNC  = 4;
    // Slave mode config fields
    localparam int SM_LSB     = 0;
    localparam int TS_LSB     = 4;
    localparam int ECM1_BIT   = 8;
    localparam int FLT_LSB    = 12;
    // Status bits
    localparam int ST_UP      = 0;
    localparam int ST_TRG     = 1;
    localparam int ST_CH      = 2;
    localparam int NUM_CH     = 4;
    localparam int NUM_EV     = 6;
    // Slave modes and trigger source selects
    localparam logic [2:0] SM_INTERNAL = 3'h0;
    localparam logic [2:0] SM_QUAD1    = 3'h1;
    localparam logic [2:0] SM_QUAD2    = 3'h2;
    localparam logic [2:0] SM_QUAD3    = 3'h3;
    localparam logic [2:0] SM_EXTCLK0  = 3'h7;
    localparam logic [2:0] TS_ITI_MAX  = 3'h3;
    localparam logic [2:0] TS_CI0      = 3'h5;
    localparam logic [2:0] TS_CI1      = 3'h6;
    localparam logic [2:0] TS_CI0ED    = 3'h4;
    localparam logic [2:0] TS_ETI      = 3'h7;
    localparam int CNT_W = 32;
    localparam int PSC_W = 16;
    localparam int FLT_W = 4;
endpackage

// file: src/gtimer.sv
`timescale 1ns/1ps
module gtimer #(
    parameter int WIDTH = 32
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              channel_input_0,
    input  wire logic              channel_input_1,
    input  wire logic [3:0]        internal_trigger_inputs,
    input  wire logic              external_trigger_input,
    input  wire logic              sync_start_in,
    output logic                   sync_start_out,
    output logic [3:0]             compare_out,
    output logic                   irq,
    output logic                   prescaled_clock
);
    // Registers
    logic [31:0]      ctrl;
    logic [15:0]      slave_mode_config_reg;
    logic [15:0]      prescaler_value;
    logic [15:0]      psc_shadow;
    logic [15:0]      psc_count;
    logic [WIDTH-1:0] car;
    logic [WIDTH-1:0] counter;
    logic [WIDTH-1:0] chcv [gtimer_pkg::NUM_CH];
    logic [7:0]       chctl;
    logic [gtimer_pkg::NUM_EV-1:0] stat;
    logic [gtimer_pkg::NUM_EV-1:0] mask;
    logic             dir_down;
    logic             prev_src;
    logic [3:0]       cap_prev;

    // Three-stage synchronisers for pins
    logic [2:0] s_ci0, s_ci1, s_eti, s_sync;
    logic [2:0] s_iti [4];
    logic ci0, ci1, eti_raw, sync_in;
    logic [3:0] iti;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_ci0  <= 3'h0;
            s_ci1  <= 3'h0;
            s_eti  <= 3'h0;
            s_sync <= 3'h0;
            for (int i = 0; i < 4; i++) s_iti[i] <= 3'h0;
        end else begin
            s_ci0  <= {s_ci0[1:0], channel_input_0};
            s_ci1  <= {s_ci1[1:0], channel_input_1};
            s_eti  <= {s_eti[1:0], external_trigger_input};
            s_sync <= {s_sync[1:0], sync_start_in};
            for (int i = 0; i < 4; i++) s_iti[i] <= {s_iti[i][1:0], internal_trigger_inputs[i]};
        end
    end

    // Accepted level changes only once stages two and three agree
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ci0     <= 1'b0;
            ci1     <= 1'b0;
            eti_raw <= 1'b0;
            sync_in <= 1'b0;
            iti     <= 4'h0;
        end else begin
            if (s_ci0[1] == s_ci0[2]) ci0 <= s_ci0[2];
            if (s_ci1[1] == s_ci1[2]) ci1 <= s_ci1[2];
            if (s_eti[1] == s_eti[2]) eti_raw <= s_eti[2];
            if (s_sync[1] == s_sync[2]) sync_in <= s_sync[2];
            for (int i = 0; i < 4; i++)
                if (s_iti[i][1] == s_iti[i][2]) iti[i] <= s_iti[i][2];
        end
    end

    // Digital filter: level must hold for the programmed run length
    logic [3:0] flt_cnt;
    logic       eti_filt;
    wire  [3:0] flt_len = slave_mode_config_reg[gtimer_pkg::FLT_LSB +: gtimer_pkg::FLT_W];
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            flt_cnt  <= 4'h0;
            eti_filt <= 1'b0;
        end else if (eti_raw == eti_filt) begin
            flt_cnt <= 4'h0;
        end else if (flt_cnt >= flt_len) begin
            eti_filt <= eti_raw;
            flt_cnt  <= 4'h0;
        end else begin
            flt_cnt <= flt_cnt + 4'h1;
        end
    end

    // Clock source selection
    wire [2:0] slave_mode_select     = slave_mode_config_reg[gtimer_pkg::SM_LSB +: 3];
    wire [2:0] trigger_source_select = slave_mode_config_reg[gtimer_pkg::TS_LSB +: 3];
    wire       ext_clock_mode1_enable = slave_mode_config_reg[gtimer_pkg::ECM1_BIT];
    wire       count_enable = ctrl[gtimer_pkg::CTRL_CEN];
    wire       mode_ext0 = (slave_mode_select == gtimer_pkg::SM_EXTCLK0);
    wire       mode_quad = (slave_mode_select == gtimer_pkg::SM_QUAD1) ||
                           (slave_mode_select == gtimer_pkg::SM_QUAD2) ||
                           (slave_mode_select == gtimer_pkg::SM_QUAD3);
    wire       use_eti = ext_clock_mode1_enable ||
                         (mode_ext0 && trigger_source_select == gtimer_pkg::TS_ETI);
    wire       src_any_edge = mode_ext0 && trigger_source_select == gtimer_pkg::TS_CI0ED;
    logic      src_level;
    always_comb begin
        src_level = 1'b0;
        if (use_eti)
            src_level = eti_filt;
        else if (trigger_source_select <= gtimer_pkg::TS_ITI_MAX)
            src_level = iti[trigger_source_select[1:0]];
        else if (trigger_source_select == gtimer_pkg::TS_CI1)
            src_level = ci1;
        else
            src_level = ci0;
    end
    // One edge per module clock at most; ITI counts rising only, EXTERNAL_TRIGGER_INPUT too except with ECM1 set in mode 7 with CI0ED selected
    wire src_rise = src_level & ~prev_src;
    wire src_edge = src_any_edge ? (src_level ^ prev_src) : src_rise;

    // Quadrature decoder: x4 decoding of ci0/ci1
    logic q0, q1;
    wire  q_step = (ci0 ^ q0) | (ci1 ^ q1);
    wire  q_down = ci0 ^ q1;
    wire  ext_tick = (mode_ext0 || ext_clock_mode1_enable) && src_edge;
    wire  drive_tick = mode_quad ? q_step : (use_eti || mode_ext0) ? ext_tick : 1'b1;

    // Synchronised start
    wire run = count_enable;

    // Prescaler and counter
    wire psc_done = (psc_count == psc_shadow);
    wire cnt_tick = run && drive_tick && psc_done;
    wire [1:0] cam = ctrl[gtimer_pkg::CTRL_CAM +: 2];
    wire down_now = mode_quad ? q_down : (cam != 2'b00) ? dir_down : ctrl[gtimer_pkg::CTRL_DIR];
    wire at_top = (counter >= car);
    wire at_bot = (counter == '0);
    wire ovf = cnt_tick && !down_now && at_top;
    wire udf = cnt_tick && down_now && at_bot;
    // Write strobe, taken once per bus cycle while ack is still low
    wire wb_we_ok = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    wire sw_upd = wb_we_ok && wb_adr_i == gtimer_pkg::OFF_SWEV && wb_dat_i[0];
    wire update = ovf || udf || sw_upd;
    wire trig_ev = ext_tick;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            psc_count  <= 16'h0000;
            psc_shadow <= 16'h0000;
            prev_src   <= 1'b0;
            q0         <= 1'b0;
            q1         <= 1'b0;
        end else begin
            prev_src <= src_level;
            q0       <= ci0;
            q1       <= ci1;
            if (update) psc_shadow <= prescaler_value;
            if (update) psc_count <= 16'h0000;
            else if (run && drive_tick) psc_count <= psc_done ? 16'h0000 : psc_count + 16'h1;
        end
    end

    // Counter with up, down and centre-aligned modes
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            counter  <= '0;
            dir_down <= 1'b0;
        end else if (sw_upd) begin
            counter  <= (cam == 2'b00 && ctrl[gtimer_pkg::CTRL_DIR]) ? car : '0;
            dir_down <= 1'b0;
        end else if (cnt_tick) begin
            if (!down_now) begin
                if (at_top && cam == 2'b00) counter <= '0;
                else if (at_top) begin
                    counter  <= counter - 1'b1;
                    dir_down <= 1'b1;
                end else counter <= counter + 1'b1;
            end else begin
                if (at_bot && cam == 2'b00 && !mode_quad) counter <= car;
                else if (at_bot && !mode_quad) begin
                    counter  <= counter + 1'b1;
                    dir_down <= 1'b0;
                end else counter <= counter - 1'b1;
            end
        end
    end

    // Channels: capture on the rising edge of own input (ci0, ci1, iti[0], iti[1]) when capture bit set, else compare
    wire [3:0] ch_cap  = chctl[3:0];
    wire [3:0] ch_en   = chctl[7:4];
    logic [3:0] ch_ev;
    logic [3:0] cap_in;
    assign cap_in = {iti[1], iti[0], ci1, ci0};
    always_comb begin
        for (int i = 0; i < 4; i++)
            ch_ev[i] = ch_en[i] && (ch_cap[i] ? (cap_in[i] & ~cap_prev[i])
                                              : (cnt_tick && counter == chcv[i]));
    end

    // Event status, write-one-to-clear; a set wins over the clear
    wire [gtimer_pkg::NUM_EV-1:0] ev_set = {ch_ev, trig_ev, update};
    wire stat_wr = wb_we_ok && wb_adr_i == gtimer_pkg::OFF_STAT;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stat     <= '0;
            cap_prev <= 4'h0;
            for (int i = 0; i < 4; i++) chcv[i] <= '0;
        end else begin
            cap_prev <= cap_in;
            stat <= (stat & ~(stat_wr ? wb_dat_i[gtimer_pkg::NUM_EV-1:0] : '0)) | ev_set;
            for (int i = 0; i < 4; i++)
                if (ch_ev[i] && ch_cap[i]) chcv[i] <= counter;
                else if (wb_we_ok && wb_adr_i == gtimer_pkg::OFF_CHCV0 + 8'(4*i) && !ch_cap[i])
                    chcv[i] <= wb_dat_i[WIDTH-1:0];
        end
    end

    // Register writes
    wire sync_go = ctrl[gtimer_pkg::CTRL_SYNC] && sync_in;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            ctrl                  <= 32'h0;
            slave_mode_config_reg <= 16'h0;
            prescaler_value       <= 16'h0;
            car                   <= '1;
            chctl                 <= 8'h0;
            mask                  <= '0;
        end else begin
            if (sync_go) ctrl[gtimer_pkg::CTRL_CEN] <= 1'b1;
            if (wb_we_ok) begin
                case (wb_adr_i)
                    gtimer_pkg::OFF_CTRL:  ctrl <= wb_dat_i;
                    gtimer_pkg::OFF_SMCFG: slave_mode_config_reg <= wb_dat_i[15:0];
                    gtimer_pkg::OFF_PSC:   prescaler_value <= wb_dat_i[15:0];
                    gtimer_pkg::OFF_CAR:   car <= wb_dat_i[WIDTH-1:0];
                    gtimer_pkg::OFF_CHCTL: chctl <= wb_dat_i[7:0];
                    gtimer_pkg::OFF_MASK:  mask <= wb_dat_i[gtimer_pkg::NUM_EV-1:0];
                    default: ;
                endcase
            end
        end
    end

    // Read mux
    logic [31:0] rd;
    always_comb begin
        rd = 32'h0;
        case (wb_adr_i)
            gtimer_pkg::OFF_CTRL:  rd = ctrl;
            gtimer_pkg::OFF_SMCFG: rd = {16'h0, slave_mode_config_reg};
            gtimer_pkg::OFF_PSC:   rd = {16'h0, prescaler_value};
            gtimer_pkg::OFF_CAR:   rd = 32'(car);
            gtimer_pkg::OFF_CNT:   rd = 32'(counter);
            gtimer_pkg::OFF_STAT:  rd = 32'(stat);
            gtimer_pkg::OFF_MASK:  rd = 32'(mask);
            gtimer_pkg::OFF_CHCTL: rd = {24'h0, chctl};
            default: begin
                for (int i = 0; i < 4; i++)
                    if (wb_adr_i == gtimer_pkg::OFF_CHCV0 + 8'(4*i)) rd = 32'(chcv[i]);
            end
        endcase
    end

    // Bus answer and registered outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wb_ack_o        <= 1'b0;
            wb_dat_o        <= 32'h0;
            irq             <= 1'b0;
            sync_start_out  <= 1'b0;
            compare_out     <= 4'h0;
            prescaled_clock <= 1'b0;
        end else begin
            wb_ack_o        <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            wb_dat_o        <= rd;
            irq             <= |(stat & mask);
            sync_start_out  <= count_enable;
            prescaled_clock <= cnt_tick;
            for (int i = 0; i < 4; i++) compare_out[i] <= !ch_cap[i] && (counter >= chcv[i]);
        end
    end

    // Checks on the clock source path, flags, interrupt and bus; all sampled on the module clock

    // A filtered trigger rise must reach the counter when undivided
    AST_ETI_TICK: assert property (@(posedge clock) disable iff (reset)
        (use_eti && !mode_quad && run && eti_filt && !prev_src && psc_shadow == 16'h0)
        |=> prescaled_clock) else $error("eti rise gave no tick");

    // Internal source ticks every cycle when undivided
    AST_INTERNAL: assert property (@(posedge clock) disable iff (reset)
        (slave_mode_select == 3'h0 && !ext_clock_mode1_enable && run && psc_shadow == 16'h0)
        |=> prescaled_clock) else $error("internal clock tick missing");

    // Nothing counts while stopped
    AST_NO_RUN: assert property (@(posedge clock) disable iff (reset)
        !run |=> !prescaled_clock) else $error("tick without enable");

    // Shadow only moves on an update, so a new factor never cuts a period short
    AST_PSC_HOLD: assert property (@(posedge clock) disable iff (reset)
        !update |=> $stable(psc_shadow)) else $error("prescaler loaded early");

    // Shadow takes the programmed factor on an update
    AST_PSC_LOAD: assert property (@(posedge clock) disable iff (reset)
        update |=> psc_shadow == $past(prescaler_value)) else $error("prescaler not loaded");

    // Interrupt level follows the unmasked flags
    AST_IRQ: assert property (@(posedge clock) disable iff (reset)
        |(stat & mask) |=> irq) else $error("irq missing");

    // Update flag is set by every update event
    AST_STAT_SET: assert property (@(posedge clock) disable iff (reset)
        update |=> stat[gtimer_pkg::ST_UP]) else $error("update flag not set");

    // Slave modes 4 to 6 still run from the module clock while ECM1 is clear
    AST_MODE_CLOCK: assert property (@(posedge clock) disable iff (reset)
        (slave_mode_select >= 3'h4 && slave_mode_select <= 3'h6 && !ext_clock_mode1_enable
         && run && psc_shadow == 16'h0) |=> prescaled_clock)
        else $error("module clock tick missing in slave mode");

    // External sources tick only on a detected edge, never twice per edge
    AST_EXT_EDGE: assert property (@(posedge clock) disable iff (reset)
        ((use_eti || mode_ext0) && !mode_quad && !src_edge) |=> !prescaled_clock)
        else $error("tick without source edge");

    // Filter output only ever moves to the level that it has been watching
    AST_FILTER: assert property (@(posedge clock) disable iff (reset)
        !$stable(eti_filt) |-> eti_filt == $past(eti_raw))
        else $error("filter took a level it never saw");

    // Start indication follows count enable one cycle later
    AST_SYNC_OUT: assert property (@(posedge clock) disable iff (reset)
        1'b1 |=> sync_start_out == $past(count_enable))
        else $error("start indication lags");

    // Counter holds between ticks
    AST_CNT_HOLD: assert property (@(posedge clock) disable iff (reset)
        (!cnt_tick && !sw_upd) |=> $stable(counter)) else $error("counter moved without tick");

    // Bus acknowledge is a single-cycle pulse
    AST_ACK_PULSE: assert property (@(posedge clock) disable iff (reset)
        wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
endmodule

// file: tb/general_timer_clock_source_test.sv
`timescale 1ns/1ps
module general_timer_clock_source_test;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        channel_input_0;
    logic        channel_input_1;
    logic [3:0]  internal_trigger_inputs;
    logic        external_trigger_input;
    logic        sync_start_in;
    logic [3:0]  compare_out;
    logic        sync_start_out;
    logic        irq;
    logic        prescaled_clock;
    logic [31:0] ticks = 32'h0;
    logic [31:0] base;
    logic [31:0] rd;
    int          n_mismatch = 0;
    int          samples_checked = 0;

    always #2.5 clock = ~clock;

    gtimer #(.WIDTH(32)) dut (
        .clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .channel_input_0(channel_input_0),
        .channel_input_1(channel_input_1), .internal_trigger_inputs(internal_trigger_inputs),
        .external_trigger_input(external_trigger_input), .sync_start_in(sync_start_in),
        .sync_start_out(sync_start_out), .compare_out(compare_out), .irq(irq),
        .prescaled_clock(prescaled_clock)
    );

    trigger_source_model far (
        .clock(clock), .internal_trigger_inputs(internal_trigger_inputs),
        .channel_input_0(channel_input_0), .channel_input_1(channel_input_1),
        .external_trigger_input(external_trigger_input), .sync_start_in(sync_start_in)
    );

    // Running count of prescaler ticks; scenarios take differences
    always @(posedge clock) begin
        if (prescaled_clock === 1'b1) begin
            ticks <= ticks + 32'h1;
        end
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic cycle: hold until ack is sampled high, release at that edge
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
        int k;
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        wb_sel_i <= 4'hf;
        k = 0;
        @(posedge clock);
        while (wb_ack_o !== 1'b1 && k < 20) begin
            @(posedge clock);
            k++;
        end
        check("bus ack", {31'h0, wb_ack_o}, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task wait_ticks(input int cycles, input logic [31:0] exp);
        @(posedge clock);
        base = ticks;
        repeat (cycles) @(posedge clock);
        check("tick count", ticks - base, exp);
    endtask

    // Stop, reconfigure, restart, then pulse one far-side line
    task count_edges(input logic [31:0] cfg, input logic [2:0] sel, input int n,
                     input int w, input logic [31:0] exp);
        wb(1'b1, gtimer_pkg::OFF_CTRL, 32'h0);
        wb(1'b1, gtimer_pkg::OFF_SMCFG, cfg);
        wb(1'b1, gtimer_pkg::OFF_CTRL, 32'h1);
        repeat (10) @(posedge clock);
        base = ticks;
        far.burst(sel, n, w);
        repeat (40) @(posedge clock);
        check("edge ticks", ticks - base, exp);
    endtask

    task test_defaults;
        wb(1'b0, gtimer_pkg::OFF_SMCFG, 32'h0);
        check("mode reset", rd, 32'h0);
        wb(1'b0, gtimer_pkg::OFF_CAR, 32'h0);
        check("reload reset", rd, 32'hffffffff);
        check("start idle", {31'h0, sync_start_out}, 32'h0);
        check("compare out", {28'h0, compare_out}, 32'hf);
        wait_ticks(20, 32'h0);
        wb(1'b1, gtimer_pkg::OFF_CTRL, 32'h1);
        repeat (4) @(posedge clock);
        check("start out", {31'h0, sync_start_out}, 32'h1);
        wait_ticks(20, 32'd20);
    endtask

    task test_ext_sources;
        for (int t = 0; t < 4; t++) begin
            count_edges(32'h7 | (t << 4), t[2:0], 3, 8, 32'd3);
        end
        count_edges(32'h07, 3'h1, 3, 8, 32'd0);
        count_edges(32'h57, 3'h4, 3, 8, 32'd3);
        count_edges(32'h67, 3'h5, 3, 8, 32'd3);
        count_edges(32'h47, 3'h4, 3, 8, 32'd6);
        count_edges(32'h100, 3'h6, 3, 8, 32'd3);
        count_edges(32'h77, 3'h6, 3, 8, 32'd3);
        // Long filter swallows short pulses but passes wide ones
        count_edges(32'hf100, 3'h6, 3, 4, 32'd0);
        count_edges(32'hf100, 3'h6, 2, 30, 32'd2);
    endtask

    // Prescaler load waits for an update; mode 4 keeps the module clock
    task test_prescaler;
        wb(1'b1, gtimer_pkg::OFF_SMCFG, 32'h4);
        wb(1'b1, gtimer_pkg::OFF_PSC, 32'h2);
        repeat (4) @(posedge clock);
        wait_ticks(30, 32'd30);
        wb(1'b1, gtimer_pkg::OFF_SWEV, 32'h1);
        repeat (4) @(posedge clock);
        wait_ticks(30, 32'd10);
    endtask

    task test_interrupt;
        wb(1'b1, gtimer_pkg::OFF_CTRL, 32'h0);
        wb(1'b1, gtimer_pkg::OFF_STAT, 32'h3f);
        wb(1'b1, gtimer_pkg::OFF_MASK, 32'h1);
        wb(1'b1, gtimer_pkg::OFF_SWEV, 32'h1);
        repeat (3) @(posedge clock);
        check("irq set", {31'h0, irq}, 32'h1);
        wb(1'b0, gtimer_pkg::OFF_STAT, 32'h0);
        check("update flag", rd & 32'h1, 32'h1);
        wb(1'b1, gtimer_pkg::OFF_MASK, 32'h0);
        repeat (3) @(posedge clock);
        check("irq masked", {31'h0, irq}, 32'h0);
        wb(1'b1, gtimer_pkg::OFF_MASK, 32'h1);
        wb(1'b1, gtimer_pkg::OFF_STAT, 32'h1);
        repeat (3) @(posedge clock);
        check("irq cleared", {31'h0, irq}, 32'h0);
    endtask

    task test_unmapped;
        wb(1'b1, 8'h80, 32'ha5a5a5a5);
        wb(1'b0, 8'h80, 32'h0);
        check("unmapped read", rd, 32'h0);
    endtask

    task conclude;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        test_defaults;
        test_ext_sources;
        test_prescaler;
        test_interrupt;
        test_unmapped;
        conclude;
    end

    // Whole run needs well under 10k cycles
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        conclude;
    end
endmodule

// file: tb/trigger_source_model.sv
`timescale 1ns/1ps
// Far-side pins: other timers' trigger outputs and the external input pins
module trigger_source_model (
    input  wire logic       clock,
    output logic [3:0]      internal_trigger_inputs,
    output logic            channel_input_0,
    output logic            channel_input_1,
    output logic            external_trigger_input,
    output logic            sync_start_in
);
    // All lines idle low; start on sync is never requested here
    initial begin
        internal_trigger_inputs = 4'h0;
        channel_input_0 = 1'b0;
        channel_input_1 = 1'b0;
        external_trigger_input = 1'b0;
        sync_start_in = 1'b0;
    end

    // Select 0-3 trigger inputs, 4 and 5 channel inputs, 6 external trigger
    task drive(input logic [2:0] sel, input logic v);
        case (sel)
            3'h4: channel_input_0 <= v;
            3'h5: channel_input_1 <= v;
            3'h6: external_trigger_input <= v;
            default: internal_trigger_inputs[sel[1:0]] <= v;
        endcase
    endtask

    // Pulses of w cycles high then w low; short ones test the filter
    task burst(input logic [2:0] sel, input int n, input int w);
        repeat (n) begin
            @(posedge clock);
            drive(sel, 1'b1);
            repeat (w) @(posedge clock);
            drive(sel, 1'b0);
            repeat (w) @(posedge clock);
        end
    endtask
endmodule
